// ### inc/asq_pkg.sv
// Constants, register map and state codes for the converter state sequencer.
// Assumes a single 100 MHz master clock feeding every user of this package.
package asq_pkg;

	// Master clock
	localparam int unsigned ASQ_CLK_FREQ_HZ = 100_000_000;

	// Power-on hold time and its cycle count
	localparam int unsigned ASQ_POR_TIME_MS = 10;
	localparam int unsigned ASQ_POR_CYCLES = ASQ_POR_TIME_MS * (ASQ_CLK_FREQ_HZ / 1000);

	// Sequencer periods in master clock cycles
	localparam logic [19:0] ASQ_WAKE_CYCLES = 20'h00708;
	localparam logic [19:0] ASQ_CAL_CYCLES = 20'h00CAE;
	localparam logic [19:0] ASQ_CAL_OFFSET_CYCLES = 20'h00657;
	localparam logic [19:0] ASQ_CAL_GAIN_CYCLES = ASQ_CAL_CYCLES - ASQ_CAL_OFFSET_CYCLES;
	localparam logic [19:0] ASQ_CONVERT_REQUEST_CONT_CYCLES = 20'h00656;
	localparam logic [19:0] ASQ_CONVERT_REQUEST_START_CYCLES = 20'h00658;

	// Result coding
	localparam logic [19:0] ASQ_BIPOLAR_OFFSET = 20'h80000;
	localparam logic [19:0] ASQ_FULL_SCALE = 20'hFFFFF;
	localparam logic [19:0] ASQ_OFFSET_COEF_RST = 20'h00000;
	localparam logic [19:0] ASQ_GAIN_COEF_RST = 20'h80000;
	localparam int unsigned ASQ_GAIN_FRAC_BITS = 19;

	// Register byte offsets
	localparam logic [7:0] ASQ_REG_CTRL = 8'h00;
	localparam logic [7:0] ASQ_REG_STATUS = 8'h04;
	localparam logic [7:0] ASQ_REG_RESULT = 8'h08;
	localparam logic [7:0] ASQ_REG_OFFSET_COEF = 8'h0C;
	localparam logic [7:0] ASQ_REG_GAIN_COEF = 8'h10;

	// Field positions
	localparam int unsigned ASQ_CTRL_SOFT_CAL = 0;
	localparam int unsigned ASQ_STAT_STATE_LSB = 0;
	localparam int unsigned ASQ_STAT_CHANNEL = 3;
	localparam int unsigned ASQ_STAT_POLARITY = 4;
	localparam int unsigned ASQ_STAT_READY = 5;
	localparam int unsigned ASQ_STAT_CAL_DONE = 6;

	typedef enum logic [2:0] {
		ASQ_ST_POR = 3'b000,
		ASQ_ST_WAKE = 3'b001,
		ASQ_ST_STANDBY = 3'b010,
		ASQ_ST_CAL_OFFSET = 3'b011,
		ASQ_ST_CAL_GAIN = 3'b100,
		ASQ_ST_CONVERT = 3'b101
	} asq_state_t;

endpackage : asq_pkg

// ### src/asq_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous levels, slow compared to clk.
`timescale 1ns/1ps
`default_nettype none
module asq_sync #(
	parameter int WIDTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output var logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule : asq_sync
`default_nettype wire

// ### src/asq_sequencer.sv
// Control sequencer of a two-channel delta-sigma converter with an APB register port.
// Assumes request pins are asynchronous, filter_word is on clk, APB runs on clk.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module asq_sequencer
	import asq_pkg::*;
#(
	parameter int unsigned POR_CYCLES = ASQ_POR_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic calibrate_request,
	input wire logic convert_request,
	input wire logic channel_select,
	input wire logic polarity_select,
	input wire logic [19:0] filter_word,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic result_ready_n,
	output logic [19:0] result_word,
	output logic analog_select,
	output logic modulator_enable
);

	localparam logic [19:0] POR_LAST = 20'(POR_CYCLES - 1);

	asq_state_t state;
	logic [3:0] pins;
	logic cal_lvl;
	logic convert_request_lvl;
	logic chan_lvl;
	logic pol_lvl;
	logic convert_request_d;
	logic convert_request_rise;
	logic half_en;
	logic [19:0] cnt;
	logic [19:0] convert_request_len;
	logic cnt_done;
	logic pend_cal;
	logic pend_convert_request;
	logic soft_cal;
	logic cal_done;
	logic [19:0] offset_coef;
	logic [19:0] gain_coef;
	logic [19:0] next_result;
	logic load_result;
	logic apb_access;
	logic apb_done;
	logic result_read;

	asq_sync #(
		.WIDTH(4)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in({calibrate_request, convert_request, channel_select, polarity_select}),
		.sync_out(pins)
	);

	assign cal_lvl = pins[3];
	assign convert_request_lvl = pins[2];
	assign chan_lvl = pins[1];
	assign pol_lvl = pins[0];
	assign convert_request_rise = convert_request_lvl & ~convert_request_d;
	assign cnt_done = (cnt == convert_request_len - 20'h00001);
	assign load_result = (state == ASQ_ST_CONVERT) && cnt_done && !convert_request_rise;
	assign apb_access = psel && penable && !pready;
	// Side effects land on the completing edge, when the master samples pready
	assign apb_done = psel && penable && pready;
	assign result_read = apb_done && !pwrite && (paddr == ASQ_REG_RESULT);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			convert_request_d <= 1'b0;
		else
			convert_request_d <= convert_request_lvl;
	end

	// Standby acts on its start conditions only on every other master clock, so a standby start may
	// slip by one cycle depending on phase
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			half_en <= 1'b0;
		else
			half_en <= ~half_en;
	end

	// Commands seen in power-on, wake-up or standby are remembered until calibration or conversion starts
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pend_cal <= 1'b0;
			pend_convert_request <= 1'b0;
		end
		else if (state == ASQ_ST_POR || state == ASQ_ST_WAKE || state == ASQ_ST_STANDBY)
		begin
			if (cal_lvl && convert_request_lvl)
				pend_cal <= 1'b1;
			if (convert_request_rise || (state == ASQ_ST_POR && convert_request_lvl))
				pend_convert_request <= 1'b1;
		end
		else
		begin
			pend_cal <= 1'b0;
			pend_convert_request <= 1'b0;
		end
	end

	// Main state machine and its period counter
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ASQ_ST_POR;
			cnt <= 20'h00000;
			convert_request_len <= POR_CYCLES == 0 ? 20'h00001 : POR_LAST + 20'h00001;
		end
		else
		begin
			unique case (state)
				ASQ_ST_POR:
				begin
					if (cnt == POR_LAST)
					begin
						state <= ASQ_ST_WAKE;
						cnt <= 20'h00000;
						convert_request_len <= ASQ_WAKE_CYCLES;
					end
					else
						cnt <= cnt + 20'h00001;
				end
				ASQ_ST_WAKE:
				begin
					if (cnt_done)
					begin
						cnt <= 20'h00000;
						if (pend_cal || (cal_lvl && convert_request_lvl))
						begin
							state <= ASQ_ST_CAL_OFFSET;
							convert_request_len <= ASQ_CAL_OFFSET_CYCLES;
						end
						else if (pend_convert_request)
						begin
							state <= ASQ_ST_CONVERT;
							convert_request_len <= ASQ_CONVERT_REQUEST_START_CYCLES;
						end
						else
							state <= ASQ_ST_STANDBY;
					end
					else
						cnt <= cnt + 20'h00001;
				end
				ASQ_ST_STANDBY:
				begin
					cnt <= 20'h00000;
					if (half_en)
					begin
						if (pend_cal || (cal_lvl && convert_request_lvl) || soft_cal)
						begin
							state <= ASQ_ST_CAL_OFFSET;
							convert_request_len <= ASQ_CAL_OFFSET_CYCLES;
						end
						else if (pend_convert_request || convert_request_rise)
						begin
							state <= ASQ_ST_CONVERT;
							convert_request_len <= ASQ_CONVERT_REQUEST_START_CYCLES;
						end
					end
				end
				ASQ_ST_CAL_OFFSET, ASQ_ST_CAL_GAIN:
				begin
					if (convert_request_rise && cal_lvl)
					begin
						state <= ASQ_ST_CAL_OFFSET;
						cnt <= 20'h00000;
						convert_request_len <= ASQ_CAL_OFFSET_CYCLES;
					end
					else if (cnt_done)
					begin
						cnt <= 20'h00000;
						if (state == ASQ_ST_CAL_OFFSET)
						begin
							state <= ASQ_ST_CAL_GAIN;
							convert_request_len <= ASQ_CAL_GAIN_CYCLES;
						end
						else if (convert_request_lvl)
						begin
							state <= ASQ_ST_CONVERT;
							convert_request_len <= ASQ_CONVERT_REQUEST_START_CYCLES;
						end
						else
							state <= ASQ_ST_STANDBY;
					end
					else
						cnt <= cnt + 20'h00001;
				end
				ASQ_ST_CONVERT:
				begin
					if (convert_request_rise && cal_lvl)
					begin
						state <= ASQ_ST_CAL_OFFSET;
						cnt <= 20'h00000;
						convert_request_len <= ASQ_CAL_OFFSET_CYCLES;
					end
					else if (convert_request_rise)
					begin
						cnt <= 20'h00000;
						convert_request_len <= ASQ_CONVERT_REQUEST_START_CYCLES;
					end
					else if (cnt_done)
					begin
						cnt <= 20'h00000;
						if (convert_request_lvl)
							convert_request_len <= ASQ_CONVERT_REQUEST_CONT_CYCLES;
						else
							state <= ASQ_ST_STANDBY;
					end
					else
						cnt <= cnt + 20'h00001;
				end
				default:
				begin
					state <= ASQ_ST_STANDBY;
					cnt <= 20'h00000;
				end
			endcase
		end
	end

	// Channel is caught on the convert edge; calibration leaves it alone
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			analog_select <= 1'b0;
		else if (convert_request_rise && state != ASQ_ST_CAL_OFFSET && state != ASQ_ST_CAL_GAIN)
			analog_select <= chan_lvl;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			modulator_enable <= 1'b0;
		else
			modulator_enable <= (state != ASQ_ST_POR);
	end

	// Coefficients survive until the next calibration
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			offset_coef <= ASQ_OFFSET_COEF_RST;
			gain_coef <= ASQ_GAIN_COEF_RST;
			cal_done <= 1'b0;
		end
		else if (cnt_done && !(convert_request_rise && cal_lvl))
		begin
			if (state == ASQ_ST_CAL_OFFSET)
				offset_coef <= filter_word;
			else if (state == ASQ_ST_CAL_GAIN)
			begin
				gain_coef <= filter_word;
				cal_done <= 1'b1;
			end
		end
	end

	// Scaling: (word - offset) * gain in Q1.19, bipolar shifted to offset binary.
	// Polarity is read live here, hence the host must hold it near the end.
	always_comb
	begin
		logic signed [20:0] diff;
		logic signed [41:0] prod;
		logic signed [22:0] scaled;
		diff = $signed({1'b0, filter_word}) - $signed({1'b0, offset_coef});
		prod = diff * $signed({1'b0, gain_coef});
		scaled = prod[ASQ_GAIN_FRAC_BITS+22:ASQ_GAIN_FRAC_BITS];
		if (pol_lvl)
			scaled = scaled + $signed({3'b000, ASQ_BIPOLAR_OFFSET});
		if (scaled < 0)
			next_result = 20'h00000;
		else if (scaled > $signed({3'b000, ASQ_FULL_SCALE}))
			next_result = ASQ_FULL_SCALE;
		else
			next_result = scaled[19:0];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			result_word <= 20'h00000;
		else if (load_result)
			result_word <= next_result;
	end

	// Ready stays low until software reads the result or offset calibration starts; a new result wins over
	// the read in the same cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			result_ready_n <= 1'b1;
		else if (load_result)
			result_ready_n <= 1'b0;
		else if (result_read || state == ASQ_ST_CAL_OFFSET)
			result_ready_n <= 1'b1;
	end

	// Soft calibrate is a one-shot, held until standby can act on it
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			soft_cal <= 1'b0;
		else if (apb_done && pwrite && paddr == ASQ_REG_CTRL && pwdata[ASQ_CTRL_SOFT_CAL])
			soft_cal <= 1'b1;
		else if (state == ASQ_ST_CAL_OFFSET)
			soft_cal <= 1'b0;
	end

	// APB slave: one wait state, so pready and prdata come from flops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else if (apb_access)
		begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			unique case (paddr)
				ASQ_REG_CTRL:
					prdata <= 32'h00000000;
				ASQ_REG_STATUS:
				begin
					if (!pwrite)
					begin
						prdata[ASQ_STAT_STATE_LSB +: 3] <= state;
						prdata[ASQ_STAT_CHANNEL] <= analog_select;
						prdata[ASQ_STAT_POLARITY] <= pol_lvl;
						prdata[ASQ_STAT_READY] <= ~result_ready_n;
						prdata[ASQ_STAT_CAL_DONE] <= cal_done;
					end
				end
				ASQ_REG_RESULT:
					prdata <= {12'h000, result_word};
				ASQ_REG_OFFSET_COEF:
					prdata <= {12'h000, offset_coef};
				ASQ_REG_GAIN_COEF:
					prdata <= {12'h000, gain_coef};
				default:
					pslverr <= 1'b1;
			endcase
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule : asq_sequencer
`default_nettype wire

// ### tb/asq_sequencer_asserts.sv
// Checker for the sequencer's pins and APB port.
// Assumes it is bound into asq_sequencer and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module asq_sequencer_asserts
	import asq_pkg::*;
#(
	parameter int unsigned POR_CYCLES = ASQ_POR_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic convert_request,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic result_ready_n,
	input wire logic analog_select,
	input wire logic modulator_enable
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Saturating counts, so long runs never wrap into a false pass
	logic [31:0] up;
	logic [3:0] since;
	logic convert_request_q;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			up <= 32'h0;
		else if (up != 32'hFFFFFFFF)
			up <= up + 32'h1;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			convert_request_q <= 1'b0;
			since <= 4'hF;
		end
		else
		begin
			convert_request_q <= convert_request;
			since <= (convert_request && !convert_request_q) ? 4'h0 : since + {3'h0, since != 4'hF};
		end
	chk_por_hold: assert property ($rose(modulator_enable) |-> up + 32'h2 >= POR_CYCLES)
		else $error("modulator enabled early");
	chk_ready_wake: assert property ($fell(result_ready_n) |->
		up >= POR_CYCLES + ASQ_WAKE_CYCLES + ASQ_CONVERT_REQUEST_START_CYCLES)
		else $error("result before wake-up and conversion");
	chk_chan_rise: assert property ($changed(analog_select) |-> since <= 4'h8)
		else $error("channel changed without convert rise");
	chk_read_clears: assert property (pready && !pwrite && paddr == ASQ_REG_RESULT
		|-> ##[0:1] result_ready_n)
		else $error("result read left ready low");
	chk_apb_answer: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_unmapped: assert property (pready && paddr > ASQ_REG_GAIN_COEF
		|-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	chk_err_mapped: assert property (pslverr |-> pready && paddr > ASQ_REG_GAIN_COEF)
		else $error("error on a mapped access");
	cover property ($fell(result_ready_n));
	cover property (pready && pslverr);
	cover property ($changed(analog_select));
endmodule : asq_sequencer_asserts
`default_nettype wire

// ### tb/asq_host.sv
// Host model driving the request, channel and polarity pins.
// Assumes one caller at a time; pins change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module asq_host (
	input wire logic clk,
	output var logic calibrate_request,
	output var logic convert_request,
	output var logic channel_select,
	output var logic polarity_select
);
	// Both requests high at power-on: a command held over the wake-up
	initial
	begin
		{calibrate_request, convert_request, channel_select, polarity_select} = 4'hC;
	end
	// Levels hold until the next call, so nothing wanders during a calibration
	task drive(input logic [3:0] v);
		@(posedge clk);
		{calibrate_request, convert_request, channel_select, polarity_select} <= v;
	endtask : drive
endmodule : asq_host
`default_nettype wire

// ### tb/tb_asq_sequencer.sv
// Bench for the sequencer: calibration, conversion timing, restarts, registers.
// Assumes the package, design, host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, sn) begin n_compared++; if ((sn) !== (ex)) begin mismatches++; \
	$display("BAD %s exp %h got %h", nm, ex, sn); end end
module tb_asq_sequencer
	import asq_pkg::*;
;
	localparam int unsigned POR = 20;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [19:0] filter_word = 20'h80000, result_word;
	logic pready, pslverr, result_ready_n, analog_select, modulator_enable, err;
	wire logic calibrate_request, convert_request, channel_select, polarity_select;
	int mismatches = 0, n_compared = 0, cyc = 0, t, t0;
	asq_sequencer #(.POR_CYCLES(POR)) i_asq_sequencer (.clk(clk), .rst_n(rst_n),
		.calibrate_request(calibrate_request), .convert_request(convert_request),
		.channel_select(channel_select), .polarity_select(polarity_select),
		.filter_word(filter_word), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.result_ready_n(result_ready_n), .result_word(result_word),
		.analog_select(analog_select), .modulator_enable(modulator_enable));
	asq_host i_asq_host (.clk(clk), .calibrate_request(calibrate_request),
		.convert_request(convert_request), .channel_select(channel_select),
		.polarity_select(polarity_select));
	always #5 clk = ~clk;
	// Longest path is about 22500 cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			mismatches++;
			report_and_stop();
		end
	end
	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task at(input int c);
		while (cyc < c) @(posedge clk);
	endtask : at
	task wait_fall;
		while (result_ready_n !== 1'b0) @(posedge clk);
	endtask : wait_fall
	// Start jitter from sync and half-rate phase: a small window, not an exact figure
	task win(input int lo);
		`CHK("delay", 1'b1, (cyc - t >= lo) && (cyc - t <= lo + 8))
	endtask : win
	task power_on_cal;
		at(t + 40);
		rd(ASQ_REG_STATUS);
		`CHK("state", ASQ_ST_WAKE, q[2:0])
		`CHK("mod_en", 1'b1, modulator_enable)
		rd(8'h40);
		`CHK("slverr", 1'b1, err)
		at(t + 1900);
		i_asq_host.drive(4'h4);
		at(t + 5800);
		filter_word <= 20'h80123;
		wait_fall;
		win(6690);
		t = cyc;
		rd(ASQ_REG_RESULT);
		`CHK("result", 32'h00123, q)
		`CHK("word", 20'h00123, result_word)
		rd(ASQ_REG_STATUS);
		`CHK("cal_done", 1'b1, q[ASQ_STAT_CAL_DONE])
		apb(1'b1, ASQ_REG_OFFSET_COEF, 32'h0);
		rd(ASQ_REG_OFFSET_COEF);
		`CHK("offset", 32'h80000, q)
	endtask : power_on_cal
	task continuous;
		i_asq_host.drive(4'h5);
		wait_fall;
		`CHK("period", 1622, cyc - t)
		t = cyc;
		rd(ASQ_REG_RESULT);
		`CHK("bipolar", 32'h80123, q)
	endtask : continuous
	task restart;
		at(t + 800);
		i_asq_host.drive(4'h3);
		repeat (4) @(posedge clk);
		i_asq_host.drive(4'h7);
		t = cyc;
		wait_fall;
		win(1624);
		`CHK("channel", 1'b1, analog_select)
		rd(ASQ_REG_RESULT);
	endtask : restart
	task standby_convert_request;
		i_asq_host.drive(4'h1);
		wait_fall;
		rd(ASQ_REG_RESULT);
		rd(ASQ_REG_STATUS);
		`CHK("state", ASQ_ST_STANDBY, q[2:0])
		i_asq_host.drive(4'h5);
		t = cyc;
		at(t + 1000);
		i_asq_host.drive(4'h1);
		wait_fall;
		win(1624);
		`CHK("channel", 1'b0, analog_select)
		rd(ASQ_REG_RESULT);
	endtask : standby_convert_request
	task calibrate;
		i_asq_host.drive(4'hD);
		t0 = cyc;
		at(t0 + 12);
		rd(ASQ_REG_STATUS);
		`CHK("state", ASQ_ST_CAL_OFFSET, q[2:0])
		at(t0 + 1000);
		i_asq_host.drive(4'h3);
		repeat (4) @(posedge clk);
		i_asq_host.drive(4'h7);
		at(t0 + 1700);
		rd(ASQ_REG_STATUS);
		`CHK("state", ASQ_ST_CAL_GAIN, q[2:0])
		`CHK("channel", 1'b0, analog_select)
		at(t0 + 2000);
		i_asq_host.drive(4'h9);
		repeat (4) @(posedge clk);
		i_asq_host.drive(4'hD);
		t = cyc;
		repeat (8) @(posedge clk);
		i_asq_host.drive(4'h5);
		wait_fall;
		win(4870);
		rd(ASQ_REG_RESULT);
		`CHK("result", 32'h80000, q)
		rd(ASQ_REG_GAIN_COEF);
		`CHK("gain", 32'h80123, q)
		i_asq_host.drive(4'h1);
		wait_fall;
		rd(ASQ_REG_RESULT);
		apb(1'b1, ASQ_REG_CTRL, 32'h1);
		rd(ASQ_REG_STATUS);
		`CHK("soft_cal", ASQ_ST_CAL_OFFSET, q[2:0])
	endtask : calibrate
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t = cyc;
		power_on_cal();
		continuous();
		restart();
		standby_convert_request();
		calibrate();
		report_and_stop();
	end
endmodule : tb_asq_sequencer
bind asq_sequencer asq_sequencer_asserts #(.POR_CYCLES(POR_CYCLES)) i_asq_sequencer_asserts (
	.clk(clk), .rst_n(rst_n), .convert_request(convert_request), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .result_ready_n(result_ready_n), .analog_select(analog_select),
	.modulator_enable(modulator_enable));
`default_nettype wire
